/* logic/fpwc_top.sv */
/*
 * configuration, flash-access gate and watchdog/recovery counters.
 * assumes an avalon-mm master on clk_sys and rst tied to the reset pin.
 */
`timescale 1ns/1ps
`default_nettype none
module fpwc_top #(
   parameter int CLK_KHZ = fpwc_pkg::CLK_SYS_KHZ,
   parameter int T0_MS = fpwc_pkg::OVF_MS_0,
   parameter int T1_MS = fpwc_pkg::OVF_MS_1,
   parameter int T2_MS = fpwc_pkg::OVF_MS_2,
   parameter int T3_MS = fpwc_pkg::OVF_MS_3
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pins
   input wire logic flash_if_disable,
   output logic command_busy_n,
   output logic flash_if_active,
   output logic direct_flash_mode,
   output logic clk_src_xtal,
   output logic master_clock_freq,
   // interrupt
   output logic irq
);
   import fpwc_pkg::*;

   // elaboration checks
   generate
      if (CLK_KHZ < 4096) begin : g_bad_clk
         $error("system clock too slow for master clock model");
      end
      if (T3_MS < 1 || T3_MS > 8191 || T0_MS < 1) begin : g_bad_t
         $error("overflow times must lie in 1..8191 ms");
      end
   endgenerate

   // ***********************************************************
   // state
   // ***********************************************************
   fpwc_state_e st_r, st_nxt;
   logic [31:0] cfg_r, cfg_nxt;
   logic [IRQ_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
   logic [11:0] phr_r, phr_nxt;
   logic [2:0] busy_r, busy_nxt;
   logic werr_r, werr_nxt, rerr_r, rerr_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic [31:0] acc_r, acc_nxt;
   logic [12:0] mcnt_r, mcnt_nxt;
   logic ms_r, ms_nxt;
   logic dis_s1_r, dis_s2_r;

   fpwc_tmr_if wdog_if ();
   fpwc_tmr_if rec_if ();

   // ***********************************************************
   // pin synchroniser
   // ***********************************************************
   // flash-disable comes from the board, two flops before use
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dis_s1_r <= 1'b0;
         dis_s2_r <= 1'b0;
      end else begin
         dis_s1_r <= flash_if_disable;
         dis_s2_r <= dis_s1_r;
      end
   end

   // ***********************************************************
   // decoded configuration
   // ***********************************************************
   logic [7:0] code;
   logic [12:0] mclk_khz, phr_cnt, ovf_lim;
   assign code = cfg_r[CFG_CODE_LSB +: 8];
   assign mclk_khz = cfg_r[CFG_FREQ_BIT] ? MCLK_4000_KHZ : MCLK_4096_KHZ; // [R04]

   // phrase table size and overflow interval selects
   always_comb begin
      case (cfg_r[CFG_PHR_LSB +: 2]) // [R05]
         2'b00: phr_cnt = PHR_4096;
         2'b01: phr_cnt = PHR_3072;
         2'b10: phr_cnt = PHR_2048;
         default: phr_cnt = PHR_1024;
      endcase
      case (cfg_r[CFG_OVFT_LSB +: 2]) // [R08]
         2'b00: ovf_lim = 13'(T0_MS);
         2'b01: ovf_lim = 13'(T1_MS);
         2'b10: ovf_lim = 13'(T2_MS);
         default: ovf_lim = 13'(T3_MS);
      endcase
   end

   // ***********************************************************
   // master clock model and millisecond tick
   // ***********************************************************
   // fractional accumulator gives the master-clock rate without a pll
   always_comb begin
      acc_nxt = acc_r + {19'h00000, mclk_khz}; // [R04]
      mcnt_nxt = mcnt_r;
      ms_nxt = 1'b0;
      if (acc_nxt >= 32'(CLK_KHZ)) begin
         acc_nxt = acc_nxt - 32'(CLK_KHZ);
         if (mcnt_r + 13'h0001 >= mclk_khz) begin
            mcnt_nxt = 13'h0000;
            ms_nxt = 1'b1;
         end else begin
            mcnt_nxt = mcnt_r + 13'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_r <= 32'h0000_0000;
         mcnt_r <= 13'h0000;
         ms_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         mcnt_r <= mcnt_nxt;
         ms_r <= ms_nxt;
      end
   end

   // ***********************************************************
   // bus decode
   // ***********************************************************
   logic wr_go, rd_go, busy;
   logic [31:0] bmask;
   assign wr_go = avs_write && ack_r;
   assign rd_go = avs_read && !ack_r;
   assign busy = (busy_r != 3'h0);
   assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // one wait state: every access completes on its second edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

   logic cmd_wr, c_pwrup, c_dir, c_pdwn, key_ok;
   logic [7:0] unlock;
   assign cmd_wr = wr_go && avs_address[4:2] == OFS_CMD[4:2] && !busy;
   assign unlock = avs_writedata[CMD_UNLOCK_LSB +: 8];
   assign c_pwrup = cmd_wr && avs_writedata[CMD_PWRUP_BIT];
   assign c_dir = cmd_wr && avs_writedata[CMD_DIRECT_BIT];
   assign c_pdwn = cmd_wr && avs_writedata[CMD_PDWN_BIT];
   assign key_ok = (code != LOCK_CODE) && (unlock == code); // [R01] [R02]

   // ***********************************************************
   // counters
   // ***********************************************************
   logic run_ok, restart;
   // counters stop in direct mode: nothing may pull the part out of it
   assign run_ok = (st_r == FPWC_PWRUP);
   assign restart = cfg_r[CFG_ACT_BIT] && (wdog_if.ovf || rec_if.ovf); // [R07]
   assign wdog_if.ms_tick = ms_r;
   assign wdog_if.run = run_ok;
   assign wdog_if.kick = restart || c_pwrup || (cmd_wr && avs_writedata[CMD_WKICK_BIT]);
   assign wdog_if.limit = ovf_lim;
   assign rec_if.ms_tick = ms_r;
   assign rec_if.run = run_ok;
   assign rec_if.kick = restart || c_pwrup || (cmd_wr && avs_writedata[CMD_RKICK_BIT]);
   assign rec_if.limit = ovf_lim;

   fpwc_ovf_timer u_wdog (
      .clk_sys(clk_sys),
      .rst(rst),
      .t(wdog_if.tmr)
   );

   fpwc_ovf_timer u_rec (
      .clk_sys(clk_sys),
      .rst(rst),
      .t(rec_if.tmr)
   );

   // ***********************************************************
   // control and registers
   // ***********************************************************
   logic [IRQ_W-1:0] ev;
   always_comb begin
      st_nxt = st_r;
      cfg_nxt = cfg_r;
      ien_nxt = ien_r;
      phr_nxt = phr_r;
      busy_nxt = busy ? busy_r - 3'h1 : 3'h0;
      werr_nxt = werr_r;
      rerr_nxt = rerr_r;
      ev = '0;
      // commands; direct mode swallows all of them
      if (cmd_wr && st_r != FPWC_DIRECT) begin // [R13]
         busy_nxt = 3'(BUSY_CYC);
         if (c_pdwn) begin
            st_nxt = FPWC_PWDN;
            werr_nxt = 1'b0; // [R14]
            rerr_nxt = 1'b0;
         end else if (c_dir) begin
            if (st_r == FPWC_PWRUP && key_ok && !dis_s2_r) begin // [R01] [R02]
               st_nxt = FPWC_DIRECT;
               ev[IRQ_DIRECT] = 1'b1;
            end else begin
               ev[IRQ_REFUSED] = 1'b1;
            end
         end else if (c_pwrup) begin
            st_nxt = FPWC_PWRUP;
         end
      end
      // overflow sets flags after any clear, so the set wins
      if (wdog_if.ovf) begin
         werr_nxt = 1'b1; // [R07] [R14]
         ev[IRQ_WDOG] = 1'b1;
      end
      if (rec_if.ovf) begin
         rerr_nxt = 1'b1; // [R07] [R14]
         ev[IRQ_REC] = 1'b1;
      end
      // restart keeps the current state and kicks both counters, busy while it settles
      if (restart) begin
         busy_nxt = 3'(BUSY_CYC); // [R07]
      end
      // register writes; configuration is frozen once powered up
      if (wr_go && avs_address[4:2] == OFS_CFG[4:2] && st_r == FPWC_PWDN) begin
         cfg_nxt = (cfg_r & ~(bmask & CFG_MASK)) | (avs_writedata & bmask & CFG_MASK); // [R03]
      end
      if (wr_go && avs_address[4:2] == OFS_IRQ_EN[4:2] && avs_byteenable[0]) begin
         ien_nxt = avs_writedata[IRQ_W-1:0];
      end
      if (wr_go && avs_address[4:2] == OFS_PHRASE[4:2] && avs_byteenable[1:0] == 2'b11) begin
         phr_nxt = avs_writedata[11:0];
      end
      ist_nxt = ist_r;
      if (wr_go && avs_address[4:2] == OFS_IRQ_CLR[4:2] && avs_byteenable[0]) begin
         ist_nxt = ist_r & ~avs_writedata[IRQ_W-1:0];
      end
      ist_nxt = ist_nxt | ev;
      ack_nxt = (avs_read || avs_write) && !ack_r;
   end

   // read mux, captured on the first edge of a read
   always_comb begin
      rd_nxt = rd_r;
      if (rd_go) begin
         case (avs_address[4:2])
            OFS_CFG[4:2]: rd_nxt = cfg_r;
            OFS_STATUS[4:2]: rd_nxt = {24'h000000, 1'b1, cfg_r[CFG_XTAL_BIT], rerr_r, werr_r,
                                       dis_s2_r, !busy, st_r == FPWC_DIRECT,
                                       st_r != FPWC_PWDN}; // bit 7 half-wave [R06]
            OFS_IRQ_STAT[4:2]: rd_nxt = {28'h0000000, ist_r};
            OFS_IRQ_EN[4:2]: rd_nxt = {28'h0000000, ien_r};
            OFS_PHRASE[4:2]: rd_nxt = {15'h0000, {1'b0, phr_r} < phr_cnt, 4'h0, phr_r}; // [R05]
            OFS_VERSION[4:2]: rd_nxt = {24'h000000, cfg_r[CFG_ROM_LSB +: 8]};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= FPWC_PWDN; // [R13]
         cfg_r <= CFG_RESET;
         ist_r <= '0;
         ien_r <= IRQ_EN_RESET;
         phr_r <= 12'h000;
         busy_r <= 3'h0;
         werr_r <= 1'b0;
         rerr_r <= 1'b0;
         ack_r <= 1'b0;
         rd_r <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         cfg_r <= cfg_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         phr_r <= phr_nxt;
         busy_r <= busy_nxt;
         werr_r <= werr_nxt;
         rerr_r <= rerr_nxt;
         ack_r <= ack_nxt;
         rd_r <= rd_nxt;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign avs_readdata = rd_r;
   assign command_busy_n = !busy;
   assign direct_flash_mode = (st_r == FPWC_DIRECT);
   assign flash_if_active = (st_r != FPWC_PWDN) && !dis_s2_r;
   assign clk_src_xtal = cfg_r[CFG_XTAL_BIT]; // [R03]
   assign master_clock_freq = cfg_r[CFG_FREQ_BIT]; // [R04]
   assign irq = |(ist_r & ien_r);
endmodule : fpwc_top
`default_nettype wire

/* logic/fpwc_pkg.sv */
/*
 * constants of the flash-protect / watchdog configuration block: register
 * map, field positions, reset values, encodings and timing figures.
 * assumes a 200 MHz system clock and an avalon-mm register bus.
 */
// How it works
// R01: code 0x69 refuses every direct flash access
// R02: otherwise unlock byte must equal stored code
// R03: master clock source RC or crystal selectable
// R04: 4.096 or 4.000 MHz sets internal timing
// R05: phrase count 4096/3072/2048/1024, beyond is unused
// R06: class D drive is half-wave only
// R07: overflow sets error flag, then hold or restart
// R08: overflow time 125ms, 500ms, 2s or 4s
// R09: host holds flash-disable low during playback
// R10: host holds reset low until supply settles; the bench holds the active-high rst high for 6 cycles
// R11: host starts commands only while busy_n high
// R12: host sends direct access after power-up only
// R13: direct mode left only by reset
// R14: overflow errors readable until reset or power-down
package fpwc_pkg;
   // ***********************************************************
   // register map (byte addresses)
   // ***********************************************************
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_CMD = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h0c;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
   localparam logic [4:0] OFS_IRQ_EN = 5'h14;
   localparam logic [4:0] OFS_PHRASE = 5'h18;
   localparam logic [4:0] OFS_VERSION = 5'h1c;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int CFG_CODE_LSB = 0;
   localparam int CFG_XTAL_BIT = 8;
   localparam int CFG_FREQ_BIT = 9;
   localparam int CFG_PHR_LSB = 10;
   localparam int CFG_ACT_BIT = 12;
   localparam int CFG_OVFT_LSB = 13;
   localparam int CFG_ROM_LSB = 16;
   localparam logic [31:0] CFG_MASK = 32'h00ff_7fff;
   localparam int CMD_UNLOCK_LSB = 0;
   localparam int CMD_PWRUP_BIT = 8;
   localparam int CMD_DIRECT_BIT = 9;
   localparam int CMD_PDWN_BIT = 10;
   localparam int CMD_WKICK_BIT = 11;
   localparam int CMD_RKICK_BIT = 12;
   localparam int PHR_VALID_BIT = 16;
   localparam int IRQ_WDOG = 0;
   localparam int IRQ_REC = 1;
   localparam int IRQ_REFUSED = 2;
   localparam int IRQ_DIRECT = 3;
   localparam int IRQ_W = 4;

   // ***********************************************************
   // reset values and encodings
   // ***********************************************************
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;
   localparam logic [7:0] LOCK_CODE = 8'h69;
   localparam logic [12:0] PHR_4096 = 13'h1000;
   localparam logic [12:0] PHR_3072 = 13'h0c00;
   localparam logic [12:0] PHR_2048 = 13'h0800;
   localparam logic [12:0] PHR_1024 = 13'h0400;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_SYS_KHZ = 200000;
   localparam logic [12:0] MCLK_4096_KHZ = 13'h1000;
   localparam logic [12:0] MCLK_4000_KHZ = 13'h0fa0;
   localparam int OVF_MS_0 = 125;
   localparam int OVF_MS_1 = 500;
   localparam int OVF_MS_2 = 2000;
   localparam int OVF_MS_3 = 4000;
   localparam int BUSY_CYC = 4;

   typedef enum logic [1:0] {
      FPWC_PWDN = 2'b00,
      FPWC_PWRUP = 2'b01,
      FPWC_DIRECT = 2'b10
   } fpwc_state_e;
endpackage : fpwc_pkg

/* logic/fpwc_tmr_if.sv */
/*
 * carrier between the top module and an overflow timer.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
interface fpwc_tmr_if;
   logic ms_tick;
   logic run;
   logic kick;
   logic [12:0] limit;
   logic ovf;
   modport ctl (output ms_tick, output run, output kick, output limit, input ovf);
   modport tmr (input ms_tick, input run, input kick, input limit, output ovf);
endinterface : fpwc_tmr_if
`default_nettype wire

/* logic/fpwc_ovf_timer.sv */
/*
 * overflow timer counting millisecond ticks up to a limit.
 * assumes ms_tick is a one-cycle enable on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module fpwc_ovf_timer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control side
   fpwc_tmr_if.tmr t
);
   import fpwc_pkg::*;
   logic [12:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt;

   // count ticks, wrap and pulse at the limit
   always_comb begin
      cnt_nxt = cnt_r;
      ovf_nxt = 1'b0;
      if (!t.run || t.kick) begin
         cnt_nxt = 13'h0000;
      end else if (t.ms_tick) begin
         if (cnt_r + 13'h0001 >= t.limit) begin // [R08]
            cnt_nxt = 13'h0000;
            ovf_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 13'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_r <= 13'h0000;
         ovf_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   assign t.ovf = ovf_r;
endmodule : fpwc_ovf_timer
`default_nettype wire

/* sim/fpwc_top_asserts.sv */
/* checker for fpwc_top, bound to its ports.
   assumes the one clk_sys domain and the active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module fpwc_top_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins
   input wire logic flash_if_disable,
   input wire logic command_busy_n,
   input wire logic flash_if_active,
   input wire logic direct_flash_mode,
   input wire logic clk_src_xtal,
   input wire logic master_clock_freq,
   input wire logic irq
);
   // ******
   // checks
   // ******
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic acc_w;
   // a write goes through only in its accepting cycle
   assign acc_w = avs_write && !avs_waitrequest;
   property p_direct_holds;
      direct_flash_mode |=> direct_flash_mode;
   endproperty
   a_direct_holds: assert property (p_direct_holds) else $error("direct mode left");
   property p_direct_cause;
      $rose(direct_flash_mode) |-> $past(acc_w && avs_address[4:2] == 3'h1)
         || $past(acc_w && avs_address[4:2] == 3'h1, 2);
   endproperty
   a_direct_cause: assert property (p_direct_cause) else $error("direct without cmd");
   property p_disable_gate;
      flash_if_disable [*3] |=> !flash_if_active;
   endproperty
   a_disable_gate: assert property (p_disable_gate) else $error("flash still active");
   property p_busy_len;
      $fell(command_busy_n) |-> !command_busy_n [*4] ##1 command_busy_n;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_half_wave;
      avs_read && !avs_waitrequest && avs_address[4:2] == 3'h2 |-> avs_readdata[7];
   endproperty
   a_half_wave: assert property (p_half_wave) else $error("full-wave reported");
   property p_clk_cfg;
      !acc_w |=> $stable(clk_src_xtal) && $stable(master_clock_freq);
   endproperty
   a_clk_cfg: assert property (p_clk_cfg) else $error("clock pins moved");
   property p_irq_fall;
      $fell(irq) |-> $past(acc_w);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   property p_rdata_stands;
      $changed(avs_readdata) |-> $past(avs_read);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("readdata moved");
endmodule : fpwc_top_asserts
bind fpwc_top fpwc_top_asserts u_fpwc_top_asserts (.clk_sys(clk_sys), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .flash_if_disable(flash_if_disable), .command_busy_n(command_busy_n),
   .flash_if_active(flash_if_active), .direct_flash_mode(direct_flash_mode),
   .clk_src_xtal(clk_src_xtal), .master_clock_freq(master_clock_freq), .irq(irq));
`default_nettype wire

/* sim/fpwc_host_model.sv */
/* host model: avalon-mm master and flash-disable pin driver.
   assumes its tasks are entered right after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module fpwc_host_model (
   // clock
   input wire logic clk_sys,
   // avalon-mm master
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [3:0] avs_byteenable,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins
   output logic flash_if_disable,
   input wire logic command_busy_n
);
   // byte lanes of the next transfer, set by the bench
   logic [3:0] be;
   // ******
   // bus cycles
   // ******
   // idle bus, flash interface kept on for playback
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hf;
      avs_writedata = 32'h0;
      flash_if_disable = 1'b0;
      be = 4'hf;
   end
   // sample at the edge itself, before that edge's updates land
   task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      logic w;
      // last release still pending: let one edge pass first
      if (avs_read || avs_write) @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= we;
      avs_read <= !we;
      do begin
         @(posedge clk_sys);
         w = avs_waitrequest;
         q = avs_readdata;
      end while (w);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      avs_writedata <= ~d; // released data must not look valid
   endtask : xfer
   // a command only starts with busy_n high
   task automatic cmd(input logic [31:0] d);
      logic [31:0] q;
      do @(posedge clk_sys); while (command_busy_n !== 1'b1);
      xfer(1'b1, fpwc_pkg::OFS_CMD, d, q);
   endtask : cmd
endmodule : fpwc_host_model
`default_nettype wire

/* sim/fpwc_top_tb.sv */
/* self-checking bench for fpwc_top with a host model.
   assumes CLK_KHZ 4096, so one millisecond is 4096 cycles. */
`timescale 1ns/1ps
`default_nettype none
module fpwc_top_tb;
   import fpwc_pkg::*;
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, flash_if_disable;
   logic command_busy_n, flash_if_active, direct_flash_mode, clk_src_xtal;
   logic master_clock_freq, irq;
   logic [4:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q, cfg;
   logic [11:0] idx;
   logic [3:0] be;
   int miscompares, num_checks, seed, t;
   fpwc_top #(.CLK_KHZ(4096), .T0_MS(1), .T1_MS(2), .T2_MS(3), .T3_MS(4)) u_fpwc_top (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .flash_if_disable(flash_if_disable),
      .command_busy_n(command_busy_n), .flash_if_active(flash_if_active),
      .direct_flash_mode(direct_flash_mode), .clk_src_xtal(clk_src_xtal),
      .master_clock_freq(master_clock_freq), .irq(irq));
   fpwc_host_model u_fpwc_host_model (.clk_sys(clk_sys), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .flash_if_disable(flash_if_disable),
      .command_busy_n(command_busy_n));
   // ******
   // helpers
   // ******
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_fpwc_host_model.xfer(1'b1, a, d, x);
   endtask : wr
   // reset held long; the host keeps it until supply is settled
   task automatic do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
   endtask : do_reset
   task automatic wait_irq(input int n);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
   endtask : wait_irq
   function automatic logic [12:0] phr_cnt(input logic [1:0] k);
      return (k == 2'd0) ? PHR_4096 : (k == 2'd1) ? PHR_3072 : (k == 2'd2) ? PHR_2048 : PHR_1024;
   endfunction : phr_cnt
   // avalon byte lanes widened to a bit mask
   function automatic logic [31:0] lanes(input logic [3:0] b);
      return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
   endfunction : lanes
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   // watchdog far beyond the longest expected run
   initial begin
      repeat (50000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end
   // ******
   // tests
   // ******
   initial begin
      seed = 30;
      miscompares = 0;
      num_checks = 0;
      rst = 1'b1;
      do_reset();
      u_fpwc_host_model.xfer(1'b0, OFS_CFG, 32'h0, q);
      chk(q, CFG_RESET);
      u_fpwc_host_model.xfer(1'b0, OFS_STATUS, 32'h0, q);
      chk(q, 32'h84);
      $display("test reset done");
      // every phrase count, boundary indices, random clock choices
      for (int k = 0; k < 4; k++) begin
         cfg = ($random(seed) & CFG_MASK & 32'hffff_83ff) | (k << CFG_PHR_LSB);
         wr(OFS_CFG, cfg);
         u_fpwc_host_model.xfer(1'b0, OFS_CFG, 32'h0, q);
         chk(q, cfg);
         chk({31'h0, clk_src_xtal}, {31'h0, cfg[CFG_XTAL_BIT]});
         chk({31'h0, master_clock_freq}, {31'h0, cfg[CFG_FREQ_BIT]});
         u_fpwc_host_model.cmd(32'h100);
         for (int j = 0; j < 2; j++) begin
            idx = 12'(phr_cnt(2'(k)) - 13'd1 + 13'(j));
            wr(OFS_PHRASE, {20'h0, idx});
            u_fpwc_host_model.xfer(1'b0, OFS_PHRASE, 32'h0, q);
            chk(q, {15'h0, {1'b0, idx} < phr_cnt(2'(k)), 4'h0, idx});
         end
         u_fpwc_host_model.cmd(32'h400);
         // random lanes: only enabled bytes of the inverted word land
         be = 4'($random(seed));
         u_fpwc_host_model.be = be;
         wr(OFS_CFG, ~cfg);
         u_fpwc_host_model.be = 4'hf;
         u_fpwc_host_model.xfer(1'b0, OFS_CFG, 32'h0, q);
         chk(q, cfg ^ (lanes(be) & CFG_MASK));
      end
      $display("test config done");
      // wrong unlock, right unlock, cancel attempt, then reset
      cfg = $random(seed) & 32'h0000_00ff;
      if (cfg[7:0] == LOCK_CODE) cfg = 32'h0000_0068;
      wr(OFS_CFG, cfg);
      u_fpwc_host_model.cmd(32'h100);
      u_fpwc_host_model.cmd(32'h200 | (cfg ^ 32'h1));
      u_fpwc_host_model.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
      chk({q[3:2], 1'b0, direct_flash_mode}, 4'h4);
      chk({31'h0, flash_if_active}, 32'h1);
      u_fpwc_host_model.flash_if_disable <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({31'h0, flash_if_active}, 32'h0);
      u_fpwc_host_model.flash_if_disable <= 1'b0;
      repeat (6) @(posedge clk_sys);
      u_fpwc_host_model.cmd(32'h200 | cfg);
      u_fpwc_host_model.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
      chk({q[3], direct_flash_mode}, 2'b11);
      u_fpwc_host_model.cmd(32'h400);
      repeat (8) @(posedge clk_sys);
      chk({31'h0, direct_flash_mode}, 32'h1);
      do_reset();
      chk({31'h0, direct_flash_mode}, 32'h0);
      wr(OFS_CFG, {24'h0, LOCK_CODE});
      u_fpwc_host_model.cmd(32'h100);
      u_fpwc_host_model.cmd(32'h200 | {24'h0, LOCK_CODE});
      u_fpwc_host_model.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
      chk({q[3:2], 1'b0, direct_flash_mode}, 4'h4);
      $display("test direct done");
      // overflow in the chosen time, hold action
      do_reset();
      t = $random(seed) & 3;
      wr(OFS_CFG, t << CFG_OVFT_LSB);
      wr(OFS_IRQ_EN, 32'h3);
      u_fpwc_host_model.cmd(32'h100);
      if (t > 0) repeat (t * 4096 - 64) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      wait_irq(4096 + 512);
      chk({31'h0, irq}, 32'h1);
      u_fpwc_host_model.xfer(1'b0, OFS_STATUS, 32'h0, q);
      chk({q[5:4], q[0]}, 3'b111);
      wr(OFS_IRQ_EN, 32'h0);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      u_fpwc_host_model.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
      chk(q & 32'h3, 32'h3);
      wr(OFS_IRQ_CLR, 32'h3);
      u_fpwc_host_model.xfer(1'b0, OFS_IRQ_STAT, 32'h0, q);
      chk(q & 32'h3, 32'h0);
      u_fpwc_host_model.cmd(32'h400);
      u_fpwc_host_model.xfer(1'b0, OFS_STATUS, 32'h0, q);
      chk(q & 32'h30, 32'h0);
      $display("test overflow hold done");
      // restart action: busy again with no command
      do_reset();
      wr(OFS_CFG, 32'h1 << CFG_ACT_BIT);
      wr(OFS_IRQ_EN, 32'h1);
      u_fpwc_host_model.cmd(32'h100);
      wait_irq(4096 + 512);
      t = 0;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_sys);
         if (command_busy_n === 1'b0) t = 1;
      end
      @(posedge clk_sys);
      chk(t, 1);
      $display("test overflow restart done");
      end_sim();
   end
endmodule : fpwc_top_tb
`default_nettype wire
